/* File: design/async_terminal_char_controller.sv */
// Terminal character controller: host I/O instruction decode, flags,
// character buffers and interrupt requests over a serial terminal link.
// Assumes host strobes are one-cycle pulses synchronous to sys_clk_i.
//
// Function
// - Characters move as serial ASCII, bit by bit, 110 to 4800 baud; the code runs only 110 or 150 baud.
// - Answer device code octal 10 input, 11 output; second unit 50.
// - Input request masked by mask bit 14, output by mask bit 15.
// - Separate independent 8-bit receive and transmit buffers.
// - Each half keeps its own independent busy and done flags.
// - Start sets busy, clears done, begins receive or transmit.
// - Clear zeroes busy and done and aborts transfer; pulse does nothing.
// - Read returns receive buffer in bits 8-15, zeros in 0-7.
// - Bit 8 is terminal parity, bits 9-15 the seven-bit code.
// - Load takes the host word low bits into transmit buffer.
// - Keyboard characters arrive unprompted, needing no host setup.
// - Assembled character clears input busy, sets done, requests interrupt.
// - Output busy holds during sending; end clears busy, sets done.
// - Input start with tape reader fitted fetches the next tape code.
// - Half duplex: terminal echoes itself; full duplex: host echoes.
// - Line runs 110 baud for slow models, 150 baud for fast.
// - Received data held in a register apart from the shifter.
`timescale 1ns/100ps
module async_terminal_char_controller
    import term_ctrl_pkg::*;
#(
    parameter bit          SECOND_UNIT = 1'b0,
    parameter int unsigned SLOW_CYCLES = SLOW_BIT_CYCLES,
    parameter int unsigned FAST_CYCLES = FAST_BIT_CYCLES
)
(
    // Clock, reset, enable
    input  wire logic                  sys_clk_i,
    input  wire logic                  rstn_i,
    input  wire logic                  ce_i,
    // Host I/O instruction bus
    input  wire logic                  io_strobe_i,
    input  wire logic [5:0]            io_dev_i,
    input  wire logic                  io_read_a_i,
    input  wire logic                  io_load_a_i,
    input  wire logic [1:0]            io_func_i,
    input  wire logic [WORD_WIDTH-1:0] io_data_i,
    output logic      [WORD_WIDTH-1:0] io_data_o,
    output logic                       io_data_valid_o,
    // Priority mask and requests
    input  wire logic [WORD_WIDTH-1:0] mask_i,
    output logic                       in_irq_o,
    output logic                       out_irq_o,
    // Flags
    output logic                       in_busy_o,
    output logic                       in_done_o,
    output logic                       out_busy_o,
    output logic                       out_done_o,
    // Terminal link
    input  wire logic                  fast_model_i,
    input  wire logic                  half_duplex_i,
    input  wire logic                  rx_line_i,
    output logic                       tx_line_o,
    output logic                       reader_step_o
);

    // ************************************************************
    // Instruction decode
    // ************************************************************
    logic [7:0] receive_char_buffer;
    logic [7:0] transmit_char_buffer;
    logic [7:0] rx_char;
    logic       rx_done;
    logic       tx_done;
    logic       tx_active;
    logic       next_in_busy;
    logic       next_in_done;
    logic       next_out_busy;
    logic       next_out_done;

    wire [5:0] in_code  = SECOND_UNIT ? DEV_CODE_IN_SECOND : DEV_CODE_IN_FIRST;
    wire [5:0] out_code = SECOND_UNIT ? DEV_CODE_OUT_SECOND : DEV_CODE_OUT_FIRST;
    wire in_sel    = io_strobe_i && io_dev_i == in_code;
    wire out_sel   = io_strobe_i && io_dev_i == out_code;
    // Pulse function is decoded nowhere: it leaves every flag alone
    wire in_start  = in_sel && io_func_i == FUNC_START;
    wire in_clear  = in_sel && io_func_i == FUNC_CLEAR;
    wire out_start = out_sel && io_func_i == FUNC_START;
    wire out_clear = out_sel && io_func_i == FUNC_CLEAR;
    wire in_read   = in_sel && io_read_a_i;
    wire out_load  = out_sel && io_load_a_i;

    // Data transfer precedes the function within one instruction
    wire [7:0] tx_char_src = out_load ? io_data_i[7:0] : transmit_char_buffer;
    wire       tx_go       = out_start && !out_clear;

    // Own transmission echoes on a shared half-duplex line; ignore it
    wire rx_line_seen = (half_duplex_i && tx_active) ? 1'b1 : rx_line_i;

    // ************************************************************
    // Flag next values; host clear beats hardware set
    // ************************************************************
    always_comb
    begin
        next_in_busy  = in_busy_o;
        next_in_done  = in_done_o;
        next_out_busy = out_busy_o;
        next_out_done = out_done_o;
        if (rx_done)
            next_in_busy = 1'b0;
        if (in_start)
            next_in_busy = 1'b1;
        if (in_clear)
            next_in_busy = 1'b0;
        if (in_start || in_clear)
            next_in_done = 1'b0;
        if (rx_done)
            next_in_done = 1'b1;
        if (tx_done)
            next_out_busy = 1'b0;
        if (out_start)
            next_out_busy = 1'b1;
        if (out_clear)
            next_out_busy = 1'b0;
        if (out_start || out_clear)
            next_out_done = 1'b0;
        if (tx_done)
            next_out_done = 1'b1;
    end

    // ************************************************************
    // Flags, buffers and read data
    // ************************************************************
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            in_busy_o  <= 1'b0;
            in_done_o  <= 1'b0;
            out_busy_o <= 1'b0;
            out_done_o <= 1'b0;
        end
        else if (ce_i)
        begin
            in_busy_o  <= next_in_busy;
            in_done_o  <= next_in_done;
            out_busy_o <= next_out_busy;
            out_done_o <= next_out_done;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            receive_char_buffer  <= BUF_RESET;
            transmit_char_buffer <= BUF_RESET;
            io_data_o            <= '0;
            io_data_valid_o      <= 1'b0;
            reader_step_o        <= 1'b0;
        end
        else if (ce_i)
        begin
            if (rx_done)
                receive_char_buffer <= rx_char;
            if (out_load)
                transmit_char_buffer <= io_data_i[7:0];
            io_data_o       <= in_read ? {UPPER_ZERO, receive_char_buffer} : '0;
            io_data_valid_o <= in_read;
            reader_step_o   <= in_start;
        end
    end

    // ************************************************************
    // Interrupt requests
    // ************************************************************
    assign in_irq_o  = in_done_o && !mask_i[MASK_IDX_IN];
    assign out_irq_o = out_done_o && !mask_i[MASK_IDX_OUT];

    // ************************************************************
    // Serial line engines
    // ************************************************************
    serial_char_link #(
        .SLOW_CYCLES (SLOW_CYCLES),
        .FAST_CYCLES (FAST_CYCLES)
    ) u_link (
        .sys_clk_i   (sys_clk_i),
        .rstn_i      (rstn_i),
        .ce_i        (ce_i),
        .fast_i      (fast_model_i),
        .rx_line_i   (rx_line_seen),
        .rx_abort_i  (in_clear),
        .rx_char_o   (rx_char),
        .rx_done_o   (rx_done),
        .tx_go_i     (tx_go),
        .tx_char_i   (tx_char_src),
        .tx_abort_i  (out_clear),
        .tx_line_o   (tx_line_o),
        .tx_active_o (tx_active),
        .tx_done_o   (tx_done)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence seq_pulse_only;
        ce_i && io_strobe_i && io_func_i == FUNC_PULSE && !io_read_a_i && !io_load_a_i
            && !rx_done && !tx_done;
    endsequence

    sequence seq_rx_assembled;
        ce_i && rx_done && !in_start;
    endsequence

    chk_in_start_flags: assert property (
        ce_i && in_start && !in_clear && !rx_done |=> in_busy_o && !in_done_o)
        else $error("input start did not set busy and clear done");

    chk_out_start_flags: assert property (
        ce_i && out_start && !out_clear && !tx_done |=> out_busy_o && !out_done_o && tx_active)
        else $error("output start did not set flags or begin sending");

    chk_clear_flags: assert property (
        ce_i && in_clear && !rx_done |=> !in_busy_o && !in_done_o)
        else $error("clear left input flags set");

    chk_pulse_inert: assert property (
        seq_pulse_only |=> $stable({in_busy_o, in_done_o, out_busy_o, out_done_o}))
        else $error("pulse function changed a flag");

    chk_read_format: assert property (
        ce_i && in_read |=> io_data_valid_o && io_data_o[15:8] == UPPER_ZERO
            && io_data_o[7:0] == $past(receive_char_buffer))
        else $error("read word malformed");

    chk_load_buffer: assert property (
        ce_i && out_load |=> transmit_char_buffer == $past(io_data_i[7:0]))
        else $error("transmit buffer not loaded");

    chk_rx_assembled: assert property (
        seq_rx_assembled |=> in_done_o && !in_busy_o
            && receive_char_buffer == $past(rx_char))
        else $error("assembled character not posted");

    chk_tx_busy_hold: assert property (
        tx_active |-> out_busy_o)
        else $error("output busy dropped while sending");

    chk_tx_end_flags: assert property (
        ce_i && tx_done && !out_start && !out_clear |=> out_done_o && !out_busy_o)
        else $error("end of sending did not post done");

    chk_irq_gating: assert property (
        (in_irq_o |-> in_done_o && !mask_i[MASK_IDX_IN])
            and (out_irq_o |-> out_done_o && !mask_i[MASK_IDX_OUT]))
        else $error("request raised without done or while masked");

    chk_reader_step: assert property (
        ce_i && in_start |=> reader_step_o ##1 (!reader_step_o || $past(in_start)))
        else $error("reader step not a single pulse per start");

    // ************************************************************
    // Abort, select and line checks
    // ************************************************************
    sequence seq_out_abort;
        ce_i && out_clear;
    endsequence

    chk_out_abort: assert property (
        seq_out_abort |=> !tx_active && tx_line_o && !out_busy_o && !out_done_o)
        else $error("output clear left a transfer running");

    chk_in_abort: assert property (
        ce_i && in_clear |=> !rx_done)
        else $error("input clear did not abort the character");

    chk_irq_withdraw: assert property (
        ce_i && in_clear |=> !in_irq_o)
        else $error("input request not withdrawn by clear");

    chk_foreign_code: assert property (
        ce_i && io_strobe_i && io_dev_i != in_code && io_dev_i != out_code
            && !rx_done && !tx_done
            |=> $stable({in_busy_o, in_done_o, out_busy_o, out_done_o}) && !io_data_valid_o)
        else $error("foreign device code acted on the controller");

    chk_read_idle: assert property (
        ce_i && !in_read |=> !io_data_valid_o && io_data_o == '0)
        else $error("read word shown without a read");

    chk_load_keeps_rx: assert property (
        ce_i && out_load && !rx_done |=> $stable(receive_char_buffer))
        else $error("transmit load disturbed the receive buffer");

    chk_tx_start_bit: assert property (
        ce_i && tx_go |=> tx_active && !tx_line_o)
        else $error("start did not open a frame with a start bit");

    chk_line_idle_high: assert property (
        !tx_active |-> tx_line_o)
        else $error("line not idle high outside a frame");

endmodule : async_terminal_char_controller

/* File: design/serial_char_link.sv */
// Serial receive and transmit engines for one terminal line pair.
// Assumes line inputs are synchronous to sys_clk_i.
`timescale 1ns/100ps
module serial_char_link
    import term_ctrl_pkg::*;
#(
    parameter int unsigned SLOW_CYCLES = SLOW_BIT_CYCLES,
    parameter int unsigned FAST_CYCLES = FAST_BIT_CYCLES
)
(
    // Clock, reset, enable
    input  wire logic       sys_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       ce_i,
    input  wire logic       fast_i,
    // Receiver
    input  wire logic       rx_line_i,
    input  wire logic       rx_abort_i,
    output logic [7:0]      rx_char_o,
    output logic            rx_done_o,
    // Transmitter
    input  wire logic       tx_go_i,
    input  wire logic [7:0] tx_char_i,
    input  wire logic       tx_abort_i,
    output logic            tx_line_o,
    output logic            tx_active_o,
    output logic            tx_done_o
);

    rx_state_type         rx_state;
    tx_state_type         tx_state;
    logic [CNT_WIDTH-1:0] rx_cnt;
    logic [CNT_WIDTH-1:0] tx_cnt;
    logic [2:0]           rx_bit;
    logic [2:0]           tx_bit;
    logic [7:0]           tx_shift;
    logic [1:0]           stop_left;

    wire [CNT_WIDTH-1:0] bit_len   = fast_i ? CNT_WIDTH'(FAST_CYCLES - 1)
                                            : CNT_WIDTH'(SLOW_CYCLES - 1);
    wire [CNT_WIDTH-1:0] half_len  = {1'b0, bit_len[CNT_WIDTH-1:1]};
    wire [1:0]           stop_last = (fast_i ? STOP_BITS_FAST : STOP_BITS_SLOW) - 2'h1;
    wire                 rx_tick   = rx_cnt == '0;
    wire                 tx_tick   = tx_cnt == '0;

    assign rx_done_o   = ce_i && !rx_abort_i && rx_state == RX_STOP && rx_tick;
    assign tx_done_o   = ce_i && !tx_abort_i && !tx_go_i && tx_state == TX_STOP
                         && tx_tick && stop_left == 2'h0;
    assign tx_active_o = tx_state != TX_IDLE;

    // ************************************************************
    // Receiver: start bit, eight bits LSB first, stop
    // ************************************************************
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rx_state  <= RX_IDLE;
            rx_cnt    <= '0;
            rx_bit    <= 3'h0;
            rx_char_o <= BUF_RESET;
        end
        else if (ce_i)
        begin
            if (rx_abort_i)
                rx_state <= RX_IDLE;
            else
            begin
                rx_cnt <= rx_tick ? bit_len : rx_cnt - CNT_WIDTH'(1);
                unique case (rx_state)
                    RX_IDLE:
                    begin
                        if (!rx_line_i)
                        begin
                            rx_state <= RX_START;
                            rx_cnt   <= half_len;
                        end
                    end
                    RX_START:
                    begin
                        if (rx_tick)
                        begin
                            rx_state <= rx_line_i ? RX_IDLE : RX_DATA;
                            rx_bit   <= 3'h0;
                        end
                    end
                    RX_DATA:
                    begin
                        if (rx_tick)
                        begin
                            rx_char_o <= {rx_line_i, rx_char_o[7:1]};
                            rx_bit    <= rx_bit + 3'h1;
                            if (rx_bit == 3'h7)
                                rx_state <= RX_STOP;
                        end
                    end
                    RX_STOP:
                    begin
                        if (rx_tick)
                            rx_state <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Transmitter: two stop bits at the slow rate
    // ************************************************************
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            tx_state  <= TX_IDLE;
            tx_cnt    <= '0;
            tx_bit    <= 3'h0;
            tx_shift  <= BUF_RESET;
            stop_left <= 2'h0;
            tx_line_o <= 1'b1;
        end
        else if (ce_i)
        begin
            if (tx_abort_i)
            begin
                tx_state  <= TX_IDLE;
                tx_line_o <= 1'b1;
            end
            else if (tx_go_i)
            begin
                tx_state  <= TX_START;
                tx_shift  <= tx_char_i;
                tx_cnt    <= bit_len;
                tx_line_o <= 1'b0;
            end
            else if (tx_state != TX_IDLE)
            begin
                tx_cnt <= tx_tick ? bit_len : tx_cnt - CNT_WIDTH'(1);
                if (tx_tick)
                begin
                    unique case (tx_state)
                        TX_START:
                        begin
                            tx_state  <= TX_DATA;
                            tx_bit    <= 3'h0;
                            tx_line_o <= tx_shift[0];
                            tx_shift  <= {1'b0, tx_shift[7:1]};
                        end
                        TX_DATA:
                        begin
                            tx_bit    <= tx_bit + 3'h1;
                            tx_line_o <= (tx_bit == 3'h7) ? 1'b1 : tx_shift[0];
                            tx_shift  <= {1'b0, tx_shift[7:1]};
                            if (tx_bit == 3'h7)
                            begin
                                tx_state  <= TX_STOP;
                                stop_left <= stop_last;
                            end
                        end
                        TX_STOP:
                        begin
                            stop_left <= stop_left - 2'h1;
                            if (stop_left == 2'h0)
                                tx_state <= TX_IDLE;
                        end
                        TX_IDLE:
                            tx_state <= TX_IDLE;
                    endcase
                end
            end
        end
    end

endmodule : serial_char_link

/* File: design/term_ctrl_pkg.sv */
// Shared constants and types for the terminal character controller.
// Assumes a 50 MHz system clock and the host I/O instruction strobes.
package term_ctrl_pkg;

    // ************************************************************
    // Clock and line rates
    // ************************************************************
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned BAUD_MIN        = 110;
    localparam int unsigned BAUD_MAX        = 4800;
    localparam int unsigned BAUD_SLOW       = 110;
    localparam int unsigned BAUD_FAST       = 150;
    localparam int unsigned SLOW_BIT_CYCLES = CLK_HZ / BAUD_SLOW;
    localparam int unsigned FAST_BIT_CYCLES = CLK_HZ / BAUD_FAST;
    localparam int unsigned CNT_WIDTH       = 20;
    localparam logic [1:0]  STOP_BITS_SLOW  = 2'h2;
    localparam logic [1:0]  STOP_BITS_FAST  = 2'h1;

    // ************************************************************
    // Device codes (octal 10, 11, 50, 51)
    // ************************************************************
    localparam logic [5:0] DEV_CODE_IN_FIRST   = 6'h08;
    localparam logic [5:0] DEV_CODE_OUT_FIRST  = 6'h09;
    localparam logic [5:0] DEV_CODE_IN_SECOND  = 6'h28;
    localparam logic [5:0] DEV_CODE_OUT_SECOND = 6'h29;

    // ************************************************************
    // Word layout: host bit 0 is the word MSB
    // ************************************************************
    localparam int unsigned WORD_WIDTH   = 16;
    localparam int unsigned WORD_MSB     = 15;
    localparam int unsigned CHAR_WIDTH   = 8;
    localparam int unsigned MASK_BIT_IN  = 14;
    localparam int unsigned MASK_BIT_OUT = 15;
    localparam int unsigned MASK_IDX_IN  = WORD_MSB - MASK_BIT_IN;
    localparam int unsigned MASK_IDX_OUT = WORD_MSB - MASK_BIT_OUT;
    localparam logic [7:0]  UPPER_ZERO   = 8'h00;
    localparam logic [7:0]  BUF_RESET    = 8'h00;

    // ************************************************************
    // Function field codes
    // ************************************************************
    localparam logic [1:0] FUNC_NONE  = 2'h0;
    localparam logic [1:0] FUNC_START = 2'h1;
    localparam logic [1:0] FUNC_CLEAR = 2'h2;
    localparam logic [1:0] FUNC_PULSE = 2'h3;

    // ************************************************************
    // Serial engine states
    // ************************************************************
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;

endpackage : term_ctrl_pkg

/* File: tb/async_terminal_char_controller_tb_top.sv */
// Self-checking bench for the terminal character controller.
// Assumes shortened bit counts for both line rates.
`timescale 1ns/100ps
module async_terminal_char_controller_tb_top;
    import term_ctrl_pkg::*;
    localparam int BIT = 16;
    logic        sys_clk_i, rstn_i, ce_i, io_strobe_i, io_read_a_i, io_load_a_i;
    logic [5:0]  io_dev_i;
    logic [1:0]  io_func_i;
    logic [15:0] io_data_i, io_data_o, mask_i, q[$];
    logic        io_data_valid_o, in_irq_o, out_irq_o, in_busy_o, in_done_o;
    logic        out_busy_o, out_done_o, fast_model_i, half_duplex_i, rx_line, tx_line;
    logic        reader_step_o, got_v;
    logic [7:0]  got, c;
    int          n_errors, n_compared, seed;

    async_terminal_char_controller #(.SLOW_CYCLES(BIT), .FAST_CYCLES(12)) dut_u (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .io_strobe_i(io_strobe_i),
        .io_dev_i(io_dev_i), .io_read_a_i(io_read_a_i), .io_load_a_i(io_load_a_i),
        .io_func_i(io_func_i), .io_data_i(io_data_i), .io_data_o(io_data_o),
        .io_data_valid_o(io_data_valid_o), .mask_i(mask_i), .in_irq_o(in_irq_o),
        .out_irq_o(out_irq_o), .in_busy_o(in_busy_o), .in_done_o(in_done_o),
        .out_busy_o(out_busy_o), .out_done_o(out_done_o), .fast_model_i(fast_model_i),
        .half_duplex_i(half_duplex_i), .rx_line_i(rx_line), .tx_line_o(tx_line),
        .reader_step_o(reader_step_o));
    term_model #(.BIT(BIT), .FAST(12)) model_u (.sys_clk_i(sys_clk_i), .tx_line_i(tx_line),
        .fast_i(fast_model_i), .rx_line_o(rx_line), .got_o(got), .got_v_o(got_v));

    always #10 sys_clk_i = ~sys_clk_i;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    // One instruction, strobe held for one edge
    task automatic instr(input logic [5:0] d, input logic rd, ld, input logic [1:0] f,
                         input logic [15:0] w);
        @(posedge sys_clk_i);
        io_strobe_i <= 1'b1;
        io_dev_i    <= d;
        io_read_a_i <= rd;
        io_load_a_i <= ld;
        io_func_i   <= f;
        io_data_i   <= w;
        @(posedge sys_clk_i);
        io_strobe_i <= 1'b0;
        #1;
    endtask : instr

    task automatic wait_done(input bit outh);
        for (int n = 0; n < 2000; n++)
        begin
            if ((outh ? out_done_o : in_done_o) === 1'b1)
                return;
            @(posedge sys_clk_i);
        end
        n_errors++;
        give_verdict();
    endtask : wait_done

    // Result watcher: read words and printed characters
    always @(negedge sys_clk_i)
        if (io_data_valid_o === 1'b1 || got_v === 1'b1)
        begin
            if (q.size() == 0)
                check(16'hDEAD, 16'h0000);
            else
                check(io_data_valid_o ? io_data_o : {8'h00, got}, q.pop_front());
        end

    initial
    begin
        {sys_clk_i, rstn_i, io_strobe_i, io_read_a_i, io_load_a_i, half_duplex_i} = '0;
        {io_dev_i, io_func_i, io_data_i, mask_i, fast_model_i} = '0;
        ce_i = 1'b1;
        seed = 32'h61a4a45d;
        repeat (3) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        @(posedge sys_clk_i);
        #1 check({tx_line, in_busy_o, in_done_o, out_busy_o, out_done_o}, 16'h10);
        c = 8'($random(seed));
        model_u.send_key(c);
        wait_done(1'b0);
        #1 check({in_busy_o, in_done_o, in_irq_o, out_done_o}, 16'h6);
        mask_i <= 16'h0002;
        @(posedge sys_clk_i);
        #1 check({in_irq_o, out_irq_o}, 16'h0);
        mask_i <= 16'h0000;
        instr(DEV_CODE_IN_SECOND, 1'b1, 1'b1, FUNC_START, 16'h0);
        q.push_back({8'h00, c});
        instr(DEV_CODE_IN_FIRST, 1'b1, 1'b0, FUNC_PULSE, 16'h0);
        check({in_busy_o, in_done_o}, 16'h1);
        q.push_back({8'h00, c});
        instr(DEV_CODE_IN_FIRST, 1'b1, 1'b0, FUNC_START, 16'h0);
        check({in_busy_o, in_done_o, in_irq_o, reader_step_o}, 16'h9);
        instr(DEV_CODE_IN_FIRST, 1'b0, 1'b0, FUNC_CLEAR, 16'h0);
        check({in_busy_o, in_done_o}, 16'h0);
        $display("input tests done");
        c = 8'($random(seed));
        q.push_back({8'h00, c});
        instr(DEV_CODE_OUT_FIRST, 1'b0, 1'b1, FUNC_START,
              (16'($random(seed)) & 16'hFF00) | {8'h00, c});
        check({out_busy_o, out_done_o, in_busy_o}, 16'h4);
        wait_done(1'b1);
        #1 check({out_busy_o, out_done_o, out_irq_o, tx_line}, 16'h7);
        mask_i <= 16'h0001;
        repeat (2) @(posedge sys_clk_i);
        #1 check({out_done_o, out_irq_o}, 16'h2);
        mask_i <= 16'h0000;
        check(16'(q.size()), 16'h0);
        instr(DEV_CODE_OUT_FIRST, 1'b0, 1'b1, FUNC_START, 16'h0055);
        repeat (3) @(posedge sys_clk_i);
        instr(DEV_CODE_OUT_FIRST, 1'b0, 1'b0, FUNC_CLEAR, 16'h0);
        check({out_busy_o, out_done_o}, 16'h0);
        repeat (12 * BIT) @(posedge sys_clk_i);
        #1 check({out_done_o, tx_line}, 16'h1);
        // Fast rate, half duplex: own frame must hide the keyboard line
        fast_model_i  <= 1'b1;
        half_duplex_i <= 1'b1;
        q.push_back(16'h0012);
        instr(DEV_CODE_OUT_FIRST, 1'b0, 1'b1, FUNC_START, 16'h0012);
        model_u.send_key(8'h00);
        #1 check({in_done_o, in_busy_o, out_done_o, tx_line}, 16'h3);
        $display("output tests done");
        give_verdict();
    end
endmodule : async_terminal_char_controller_tb_top

/* File: tb/term_model.sv */
// Behavioural serial terminal: keyboard sender and printer receiver.
// Assumes the line is idle high and bit timing counted in sys_clk_i cycles.
`timescale 1ns/100ps
module term_model
#(
    parameter int BIT  = 16,
    parameter int FAST = 12
)
(
    // Clock and lines
    input  wire logic       sys_clk_i,
    input  wire logic       tx_line_i,
    input  wire logic       fast_i,
    output logic            rx_line_o,
    // Captured printer character
    output logic [7:0]      got_o,
    output logic            got_v_o
);
    initial
    begin
        rx_line_o = 1'b1;
        got_o     = 8'h00;
        got_v_o   = 1'b0;
    end

    // Keystroke frame, two stop bits at either rate
    task automatic send_key(input logic [7:0] c);
        for (int i = -1; i < 10; i++)
        begin
            rx_line_o <= (i < 0) ? 1'b0 : (i < 8) ? c[i] : 1'b1;
            repeat (fast_i ? FAST : BIT) @(posedge sys_clk_i);
        end
    endtask : send_key

    // Printer side; a start bit gone by mid-bit means an aborted frame
    always
    begin
        @(negedge tx_line_i);
        repeat ((fast_i ? FAST : BIT) / 2) @(posedge sys_clk_i);
        if (tx_line_i === 1'b0)
        begin
            for (int i = 0; i < 8; i++)
            begin
                repeat (fast_i ? FAST : BIT) @(posedge sys_clk_i);
                got_o[i] <= tx_line_i;
            end
            @(posedge sys_clk_i) got_v_o <= 1'b1;
            @(posedge sys_clk_i) got_v_o <= 1'b0;
        end
    end
endmodule : term_model
